// file: design/fdms_seq.sv
/*
 command sequencer for the 4 kB data array with register port, array storage and core stall.
 assumes a core that stops fetching while stall_o is high and keeps its timers running.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fdms_map.svh"

// Summary of operation
// - two address registers hold target address
// - four page data registers hold page bytes
// - programming only clears bits, never sets
// - erase sets whole four-byte pages to ffh
// - command read returns zero on match
// - code 06h erases whole data array in normal mode
// - normal mode durations per command
// - load mode durations per command
// - command write starts operation at once
// - core held idle until operation ends
// - interrupts held off while busy
// - timers keep running during stall
// - address registers form page or byte address
// - normal mode command codes decoded
// - f0h enters, 0fh leaves load mode
// - verify compares four bytes, stores result
module fdms_seq #(
	parameter int unsigned T_ERASE_CYC      = `FDMS_CYC_US(`FDMS_T_ERASE_US),
	parameter int unsigned T_WRITE_PAGE_CYC = `FDMS_CYC_US(`FDMS_T_WRITE_PAGE_US),
	parameter int unsigned T_WRITE1_CYC     = `FDMS_CYC_US(`FDMS_T_WRITE_SINGLE_US),
	parameter int unsigned T_LOAD_PAGE_CYC  = `FDMS_CYC_US(`FDMS_T_LOAD_PAGE_US)
) (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            stall_o,
	output logic            irq_hold_o,
	output logic            load_mode_o
);
	localparam int unsigned T_READ_CYC   = `FDMS_CYC_MC(`FDMS_T_READ_PAGE_MC);
	localparam int unsigned T_VERIFY_CYC = `FDMS_CYC_MC(`FDMS_T_VERIFY_MC);
	localparam int unsigned T_READ1_CYC  = `FDMS_CYC_MC(`FDMS_T_READ_SINGLE_MC);

	fdms_pkg::fdms_bus_t bus;
	assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	logic [7:0]  page_addr_high;
	logic [7:0]  page_addr_low;
	logic [7:0]  page_byte [4];
	logic [7:0]  array_command_reg;
	logic        program_memory_load_mode;
	logic [7:0]  mem [4096];
	logic [23:0] timer;
	fdms_pkg::fdms_op_t op;

	// page commands use a 10-bit page, byte commands a 12-bit byte address
	wire [15:0] full_addr = {page_addr_high, page_addr_low};
	wire [9:0]  page_idx  = full_addr[9:0];
	wire [11:0] byte_idx  = full_addr[11:0];
	wire        page_ok   = full_addr < 16'h0400;
	wire        byte_ok   = full_addr < 16'h1000;

	wire cmd_wr = bus.wr && bus.addr == `FDMS_OFF_COMMAND && op == fdms_pkg::FDMS_OP_NONE;
	wire ld     = program_memory_load_mode;

	// load mode has no data array operations of its own
	fdms_pkg::fdms_op_t next_op;
	logic [23:0]        next_len;
	always_comb begin
		next_op = fdms_pkg::FDMS_OP_NONE;
		next_len = 24'h000000;
		case (bus.wdata)
			`FDMS_CMD_READ_PAGE: begin
				next_op = ld ? fdms_pkg::FDMS_OP_NONE : fdms_pkg::FDMS_OP_READ;
				next_len = 24'(T_READ_CYC);
			end
			`FDMS_CMD_WRITE_PAGE: begin
				next_op = fdms_pkg::FDMS_OP_WRITE;
				next_len = ld ? 24'(T_LOAD_PAGE_CYC) : 24'(T_WRITE_PAGE_CYC);
			end
			`FDMS_CMD_VERIFY_PAGE: begin
				next_op = ld ? fdms_pkg::FDMS_OP_NONE : fdms_pkg::FDMS_OP_VERIFY;
				next_len = 24'(T_VERIFY_CYC);
			end
			`FDMS_CMD_ERASE_PAGE: begin
				next_op = fdms_pkg::FDMS_OP_ERASE_PAGE;
				next_len = 24'(T_ERASE_CYC);
			end
			`FDMS_CMD_ERASE_ARRAY: begin
				next_op = fdms_pkg::FDMS_OP_ERASE_ALL;
				next_len = 24'(T_ERASE_CYC);
			end
			`FDMS_CMD_READ_SINGLE: begin
				next_op = ld ? fdms_pkg::FDMS_OP_NONE : fdms_pkg::FDMS_OP_READ1;
				next_len = 24'(T_READ1_CYC);
			end
			`FDMS_CMD_WRITE_SINGLE: begin
				next_op = fdms_pkg::FDMS_OP_WRITE1;
				next_len = 24'(T_WRITE1_CYC);
			end
			default: begin
				next_op = fdms_pkg::FDMS_OP_NONE;
				next_len = 24'h000000;
			end
		endcase
	end

	// operation and its count start on the command write itself
	wire start = cmd_wr && next_op != fdms_pkg::FDMS_OP_NONE;
	wire done  = op != fdms_pkg::FDMS_OP_NONE && timer == 24'h000001;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			op <= fdms_pkg::FDMS_OP_NONE;
			timer <= 24'h000000;
		end else if (start) begin
			op <= next_op;
			timer <= next_len;
		end else if (op != fdms_pkg::FDMS_OP_NONE) begin
			timer <= timer - 24'h000001;
			if (done)
				op <= fdms_pkg::FDMS_OP_NONE;
		end
	end

	// high from the edge after the write to the last count
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stall_o <= 1'b0;
			irq_hold_o <= 1'b0;
		end else begin
			stall_o <= start || (op != fdms_pkg::FDMS_OP_NONE && !done);
			irq_hold_o <= start || (op != fdms_pkg::FDMS_OP_NONE && !done);
		end
	end
	// only the core is stalled; nothing here gates other peripherals' clocks

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			program_memory_load_mode <= 1'b0;
		else if (cmd_wr && bus.wdata == `FDMS_CMD_ENTER_LOAD)
			program_memory_load_mode <= 1'b1;
		else if (cmd_wr && bus.wdata == `FDMS_CMD_LEAVE_LOAD)
			program_memory_load_mode <= 1'b0;
	end
	assign load_mode_o = program_memory_load_mode;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			page_addr_high <= `FDMS_RST_BYTE;
			page_addr_low <= `FDMS_RST_BYTE;
		end else if (bus.wr && op == fdms_pkg::FDMS_OP_NONE) begin
			if (bus.addr == `FDMS_OFF_ADDR_HIGH)
				page_addr_high <= bus.wdata;
			if (bus.addr == `FDMS_OFF_ADDR_LOW)
				page_addr_low <= bus.wdata;
		end
	end

	// verify result; the command register reads back the last command or the verdict
	wire vmatch = mem[{page_idx, 2'd0}] == page_byte[0] && mem[{page_idx, 2'd1}] == page_byte[1]
		&& mem[{page_idx, 2'd2}] == page_byte[2] && mem[{page_idx, 2'd3}] == page_byte[3];
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			array_command_reg <= `FDMS_RST_BYTE;
		else if (done && op == fdms_pkg::FDMS_OP_VERIFY)
			array_command_reg <= (page_ok && vmatch) ? 8'h00 : `FDMS_VERIFY_FAIL;
		else if (cmd_wr)
			array_command_reg <= bus.wdata;
	end

	// data registers, loaded by software or by a finished read
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_data
			always_ff @(posedge sys_clk_i or negedge nrst_i) begin
				if (!nrst_i)
					page_byte[g] <= `FDMS_RST_BYTE;
				else if (done && op == fdms_pkg::FDMS_OP_READ && page_ok)
					page_byte[g] <= mem[{page_idx, 2'(g)}];
				else if (done && op == fdms_pkg::FDMS_OP_READ1 && byte_ok && g == 0)
					page_byte[g] <= mem[byte_idx];
				else if (bus.wr && op == fdms_pkg::FDMS_OP_NONE
						&& bus.addr == 8'(`FDMS_OFF_BYTE_ONE + g))
					page_byte[g] <= bus.wdata;
			end
		end
	endgenerate

	// array storage; load mode targets program memory outside this block, so the data
	// array is only touched in normal mode. no reset: a real array keeps its contents.
	// programming ANDs new data in, so a zero bit is never raised back to one
	always_ff @(posedge sys_clk_i) begin
		if (done && !ld) begin
			case (op)
				fdms_pkg::FDMS_OP_WRITE:
					if (page_ok)
						for (int i = 0; i < 4; i++)
							mem[{page_idx, 2'(i)}] <= mem[{page_idx, 2'(i)}] & page_byte[i];
				fdms_pkg::FDMS_OP_WRITE1:
					if (byte_ok)
						mem[byte_idx] <= mem[byte_idx] & page_byte[0];
				fdms_pkg::FDMS_OP_ERASE_PAGE:
					if (page_ok)
						for (int i = 0; i < 4; i++)
							mem[{page_idx, 2'(i)}] <= `FDMS_ERASED;
				fdms_pkg::FDMS_OP_ERASE_ALL:
					for (int i = 0; i < 4096; i++)
						mem[i] <= `FDMS_ERASED;
				default: ;
			endcase
		end
	end

	// read port: data in the cycle after the strobe; unmapped offsets read zero
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		case (bus.addr)
			`FDMS_OFF_ADDR_HIGH:  next_rdata = page_addr_high;
			`FDMS_OFF_ADDR_LOW:   next_rdata = page_addr_low;
			`FDMS_OFF_BYTE_ONE:   next_rdata = page_byte[0];
			`FDMS_OFF_BYTE_TWO:   next_rdata = page_byte[1];
			`FDMS_OFF_BYTE_THREE: next_rdata = page_byte[2];
			`FDMS_OFF_BYTE_FOUR:  next_rdata = page_byte[3];
			`FDMS_OFF_COMMAND:    next_rdata = array_command_reg;
			default:              next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= 8'h00;
		else if (bus.rd)
			rdata_o <= next_rdata;
		else
			rdata_o <= 8'h00;
	end

	// assertion helper: counts each stall apart from the down-counter, so a slip of
	// the counter's end point shows up against the length latched at the start
	logic [23:0] chk_len;
	logic [23:0] chk_cnt;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chk_len <= 24'h000000;
			chk_cnt <= 24'h000000;
		end else if (start) begin
			chk_len <= next_len;
			chk_cnt <= 24'h000000;
		end else if (stall_o) begin
			chk_cnt <= chk_cnt + 24'h000001;
		end
	end

	sequence s_cmd(logic [7:0] c);
		cmd_wr && bus.wdata == c && !ld;
	endsequence
	sequence s_begin(fdms_pkg::fdms_op_t o, logic l);
		start && next_op == o && ld == l;
	endsequence
	AST_STALL_START: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		start |=> stall_o) else $error("stall not raised after command");
	AST_RSVD_NO_STALL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(cmd_wr && !start && !stall_o) |=> !stall_o) else $error("reserved code stalled");
	AST_READ_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_cmd(`FDMS_CMD_READ_PAGE) |=> stall_o [*8] ##53 !stall_o)
		else $error("page read length wrong");
	AST_READ1_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_cmd(`FDMS_CMD_READ_SINGLE) |=> stall_o [*8] ##29 !stall_o)
		else $error("byte read length wrong");
	AST_VERIFY_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_cmd(`FDMS_CMD_VERIFY_PAGE) |=> stall_o [*8] ##53 !stall_o)
		else $error("verify length wrong");
	AST_IRQ_HOLD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		irq_hold_o == (op != fdms_pkg::FDMS_OP_NONE))
		else $error("interrupt hold differs from operation");
	AST_BUSY_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$fell(stall_o) |-> chk_cnt == chk_len) else $error("stall length differs from command");
	AST_WRITE_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_begin(fdms_pkg::FDMS_OP_WRITE, 1'b0) |=> chk_len == 24'(T_WRITE_PAGE_CYC))
		else $error("page write length wrong");
	AST_LOAD_WRITE_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_begin(fdms_pkg::FDMS_OP_WRITE, 1'b1) |=> chk_len == 24'(T_LOAD_PAGE_CYC))
		else $error("load page write length wrong");
	AST_ERASE_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_begin(fdms_pkg::FDMS_OP_ERASE_PAGE, 1'b0) |=> chk_len == 24'(T_ERASE_CYC))
		else $error("page erase length wrong");
	AST_LOAD_ERASE_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_begin(fdms_pkg::FDMS_OP_ERASE_PAGE, 1'b1) |=> chk_len == 24'(T_ERASE_CYC))
		else $error("load page erase length wrong");
	AST_WRITE1_LEN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_begin(fdms_pkg::FDMS_OP_WRITE1, 1'b0) |=> chk_len == 24'(T_WRITE1_CYC))
		else $error("byte write length wrong");
	AST_LOAD_ENTER: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(cmd_wr && bus.wdata == `FDMS_CMD_ENTER_LOAD) |=> load_mode_o)
		else $error("load mode not entered");
	AST_LOAD_LEAVE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(cmd_wr && bus.wdata == `FDMS_CMD_LEAVE_LOAD) |=> !load_mode_o)
		else $error("load mode not left");
	AST_VERIFY_OK: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(done && op == fdms_pkg::FDMS_OP_VERIFY && page_ok && vmatch) |=> array_command_reg == 8'h00)
		else $error("verify pass not zero");
	AST_VERIFY_FAIL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(done && op == fdms_pkg::FDMS_OP_VERIFY && !(page_ok && vmatch))
		|=> array_command_reg != 8'h00) else $error("verify mismatch read as zero");
	AST_ERASE_ALL: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(done && op == fdms_pkg::FDMS_OP_ERASE_ALL && !ld) |=> mem[12'hfff] == `FDMS_ERASED)
		else $error("erase all left data");
	AST_ERASE_PAGE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(done && op == fdms_pkg::FDMS_OP_ERASE_PAGE && !ld && page_ok)
		|=> mem[{page_idx, 2'd0}] == `FDMS_ERASED && mem[{page_idx, 2'd3}] == `FDMS_ERASED)
		else $error("page erase left data");
	AST_PROG_NO_SET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(done && op == fdms_pkg::FDMS_OP_WRITE1 && !ld && byte_ok)
		|=> (mem[byte_idx] & ~$past(mem[byte_idx])) == 8'h00)
		else $error("programming raised a bit");
	AST_ADDR_HELD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		stall_o |=> $stable(page_addr_low) && $stable(page_addr_high))
		else $error("address moved while busy");
endmodule : fdms_seq

// file: design/fdms_map.svh
/*
 register offsets, reset values, command codes and timing counts of the data array sequencer.
 assumes a 200 MHz core clock and a machine cycle of 12 core clocks.
*/
`ifndef FDMS_MAP_SVH
`define FDMS_MAP_SVH
`define FDMS_OFF_ADDR_HIGH   8'h00
`define FDMS_OFF_ADDR_LOW    8'h01
`define FDMS_OFF_BYTE_ONE    8'h02
`define FDMS_OFF_BYTE_TWO    8'h03
`define FDMS_OFF_BYTE_THREE  8'h04
`define FDMS_OFF_BYTE_FOUR   8'h05
`define FDMS_OFF_COMMAND     8'h06
`define FDMS_RST_BYTE        8'h00
`define FDMS_ERASED          8'hff
`define FDMS_CMD_READ_PAGE   8'h01
`define FDMS_CMD_WRITE_PAGE  8'h02
`define FDMS_CMD_VERIFY_PAGE 8'h04
`define FDMS_CMD_ERASE_PAGE  8'h05
`define FDMS_CMD_ERASE_ARRAY 8'h06
`define FDMS_CMD_READ_SINGLE 8'h81
`define FDMS_CMD_WRITE_SINGLE 8'h82
`define FDMS_CMD_LEAVE_LOAD  8'h0f
`define FDMS_CMD_ENTER_LOAD  8'hf0
`define FDMS_VERIFY_FAIL     8'h01
`define FDMS_CLK_MHZ         200
`define FDMS_CLK_PER_MC      12
`define FDMS_T_READ_PAGE_MC  5
`define FDMS_T_VERIFY_MC     5
`define FDMS_T_READ_SINGLE_MC 3
`define FDMS_T_WRITE_PAGE_US 380
`define FDMS_T_WRITE_SINGLE_US 200
`define FDMS_T_ERASE_US      2000
`define FDMS_T_LOAD_PAGE_US  15000
`define FDMS_CYC_MC(m)       ((m) * `FDMS_CLK_PER_MC)
`define FDMS_CYC_US(u)       ((u) * `FDMS_CLK_MHZ)
`endif

// file: design/fdms_pkg.sv
/*
 types shared by the data array sequencer.
 assumes the constants of fdms_map.svh.
*/
package fdms_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fdms_bus_t;
	typedef enum logic [2:0] {FDMS_OP_NONE, FDMS_OP_READ, FDMS_OP_WRITE, FDMS_OP_VERIFY,
		FDMS_OP_ERASE_PAGE, FDMS_OP_ERASE_ALL, FDMS_OP_READ1, FDMS_OP_WRITE1} fdms_op_t;
endpackage : fdms_pkg

// file: verification/fdms_core_model.sv
/*
 core model: issues one-cycle register strobes and waits out the stall.
 assumes the fdms_seq register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module fdms_core_model (
	input  wire logic       sys_clk_i,
	input  wire logic       stall_i,
	input  wire logic       irq_hold_i,
	input  wire logic [7:0] rdata_i,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o
);
	initial begin
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		addr_o  = 8'h00;
		wdata_o = 8'h00;
	end
	// no wait on stall here, so a caller can poke a busy sequencer on purpose
	task put(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr_o    <= 1'b1;
		addr_o  <= a;
		wdata_o <= d;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
	endtask : put
	task get(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		rd_o   <= 1'b1;
		addr_o <= a;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : get
	// next access only once the stall drops; bounded so a stuck stall cannot hang
	task settle(output int n, output int m);
		n = 0;
		m = 0;
		#1;
		while (stall_i === 1'b1 && n < 1000) begin
			n = n + 1;
			if (irq_hold_i === 1'b1) begin
				m = m + 1;
			end
			@(posedge sys_clk_i);
			#1;
		end
	endtask : settle
endmodule : fdms_core_model

// file: verification/tb_flash_data_memory_sequencer.sv
/*
 testbench: command sequences through the core model, stall lengths and read-back.
 assumes short timing parameters so erase and program counts stay small.
*/
`timescale 1ns/1ps
module tb_flash_data_memory_sequencer;
	localparam int E = 20;
	localparam int P = 24;
	localparam int S = 16;
	localparam int L = 28;
	logic       sys_clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       wr, rd, stall, irq_hold, load_mode;
	logic [7:0] addr, wdata, rdata, v;
	int         bad_count = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         n, m;
	always #2.5 sys_clk_i = ~sys_clk_i;
	fdms_seq #(.T_ERASE_CYC(E), .T_WRITE_PAGE_CYC(P), .T_WRITE1_CYC(S),
		.T_LOAD_PAGE_CYC(L)) dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.stall_o(stall), .irq_hold_o(irq_hold), .load_mode_o(load_mode));
	fdms_core_model core_u (.sys_clk_i(sys_clk_i), .stall_i(stall), .irq_hold_i(irq_hold),
		.rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	task check_b(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t byte %h expected %h", $time, got, exp);
		end
	endtask : check_b
	task check_n(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			bad_count++;
			$display("ERROR t=%0t cycles %0d expected %0d", $time, got, exp);
		end
	endtask : check_n
	// stall and interrupt hold-off both measured against the expected length
	task w(input logic [7:0] a, input logic [7:0] d, input int exp);
		core_u.put(a, d);
		core_u.settle(n, m);
		check_n(n, exp);
		check_n(m, exp);
	endtask : w
	task r(input logic [7:0] a, input logic [7:0] exp);
		core_u.get(a, v);
		check_b(v, exp);
	endtask : r
	task results;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	// whole run needs about 640 cycles
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			bad_count = bad_count + 1;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 8; a++) r(8'(a), 8'h00);
		w(8'h06, 8'h06, E);
		w(8'h00, 8'h00, 0);
		w(8'h01, 8'h03, 0);
		w(8'h06, 8'h01, 60);
		for (int a = 2; a < 6; a++) r(8'(a), 8'hff);
		w(8'h03, 8'hf3, 0);
		w(8'h06, 8'h05, E);
		w(8'h06, 8'h02, P);
		w(8'h06, 8'h04, 60);
		r(8'h06, 8'h00);
		for (int a = 2; a < 6; a++) w(8'(a), 8'hff, 0);
		w(8'h06, 8'h02, P);
		w(8'h06, 8'h04, 60);
		r(8'h06, 8'h01);
		w(8'h06, 8'h01, 60);
		r(8'h03, 8'hf3);
		w(8'h01, 8'h0e, 0);
		w(8'h02, 8'h5a, 0);
		w(8'h06, 8'h82, S);
		w(8'h02, 8'h00, 0);
		w(8'h06, 8'h81, 36);
		r(8'h02, 8'h5a);
		w(8'h00, 8'h04, 0);
		w(8'h06, 8'h04, 60);
		r(8'h06, 8'h01);
		w(8'h06, 8'h03, 0);
		r(8'h06, 8'h03);
		core_u.put(8'h06, 8'h06);
		core_u.put(8'h00, 8'h77);
		core_u.settle(n, m);
		check_n(n, E - 2);
		r(8'h00, 8'h04);
		w(8'h06, 8'hf0, 0);
		check_b({7'h00, load_mode}, 8'h01);
		w(8'h06, 8'h02, L);
		w(8'h06, 8'h05, E);
		w(8'h06, 8'h82, S);
		w(8'h06, 8'h01, 0);
		w(8'h06, 8'h0f, 0);
		check_b({7'h00, load_mode}, 8'h00);
		results();
	end
endmodule : tb_flash_data_memory_sequencer
